/* rtl/csr_pkg.sv */
// Constants and carrier types for the core system control registers.
// Assumes a single core clock domain and 8-bit register file addressing.
package csr_pkg;
  // ----------------------------------------------------------------
  // Register addresses in the system group
  // ----------------------------------------------------------------
  localparam logic [7:0] CSR_ADDR_INTERRUPT_CONTROL = 8'hE6;
  localparam logic [7:0] CSR_ADDR_CPU_FLAGS = 8'hE7;
  localparam logic [7:0] CSR_ADDR_WORKING_POINTER_LOW = 8'hE8;
  localparam logic [7:0] CSR_ADDR_WORKING_POINTER_HIGH = 8'hE9;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CSR_RESET_INTERRUPT_CONTROL = 8'h87;
  localparam logic [7:0] CSR_RESET_CPU_FLAGS = 8'h00;
  localparam logic [7:0] CSR_RESET_POINTER = 8'h00;
  // ----------------------------------------------------------------
  // Interrupt control field positions
  // ----------------------------------------------------------------
  localparam int CSR_IC_GATE = 7;
  localparam int CSR_IC_PEND = 6;
  localparam int CSR_IC_ACKSEL = 5;
  localparam int CSR_IC_ENABLE = 4;
  localparam int CSR_IC_ARB = 3;
  localparam int CSR_IC_PRIO_LSB = 0;
  // ----------------------------------------------------------------
  // Flag field positions
  // ----------------------------------------------------------------
  localparam int CSR_FL_CARRY = 7;
  localparam int CSR_FL_ZERO = 6;
  localparam int CSR_FL_SIGN = 5;
  localparam int CSR_FL_OVF = 4;
  localparam int CSR_FL_DADJ = 3;
  localparam int CSR_FL_HALF = 2;
  localparam int CSR_FL_RSVD = 1;
  localparam int CSR_FL_DATA = 0;
  // ----------------------------------------------------------------
  // Pointer field positions and widths
  // ----------------------------------------------------------------
  localparam int CSR_RP_BLOCK_LSB = 3;
  localparam int CSR_RP_MODE = 2;
  localparam int CSR_BLOCK_W = 5;
  localparam int CSR_NEST_DEPTH = 7;
  // ----------------------------------------------------------------
  // Commands from the core
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CSR_CMD_NONE, CSR_CMD_EI, CSR_CMD_MASK_ALL, CSR_CMD_IACK, CSR_CMD_IRET,
    CSR_CMD_SCF, CSR_CMD_RCF, CSR_CMD_CCF, CSR_CMD_SDM, CSR_CMD_SPM,
    CSR_CMD_SRP, CSR_CMD_SRP_LOW, CSR_CMD_SRP_HIGH
  } csr_cmd_t;
  // ALU result flags; update strobes pick which flags are taken.
  typedef struct packed {
    logic carry;
    logic zero;
    logic sign;
    logic ovf;
    logic dadj;
    logic half;
  } csr_alu_flags_t;
  typedef struct packed {
    logic carry;
    logic zsv;
    logic dadj;
    logic half;
  } csr_alu_upd_t;
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csr_wr_t;
endpackage

/* rtl/csr_wreg_map.sv */
// Working register address mapper: turns r0..r15 into a register address.
// Assumes pointers are held stable by the enclosing block.
`timescale 1ns/10ps
module csr_wreg_map
  import csr_pkg::*;
(
  input wire logic [7:0] pointer_low,
  input wire logic [7:0] pointer_high,
  input wire logic [3:0] wreg_index,
  output logic [7:0] phys_addr
);
  wire logic twin_mode;
  wire logic [4:0] low_block;
  wire logic [4:0] sel_block;
  assign twin_mode = pointer_low[CSR_RP_MODE];
  assign low_block = pointer_low[7:CSR_RP_BLOCK_LSB];
  // Single mode rounds down to an even block; index bit 3 picks the odd one
  assign sel_block = twin_mode
    ? (wreg_index[3] ? pointer_high[7:CSR_RP_BLOCK_LSB] : low_block)
    : {low_block[4:1], wreg_index[3]};
  assign phys_addr = {sel_block, wreg_index[2:0]};
endmodule

/* rtl/csr_regs.sv */
// System control registers: interrupt control, flags, working pointers.
// Assumes the core issues one command per clock and handles stacking.
//
// Notes on behaviour
// - Interrupt control resets to 87h.
// - Timer enable is global gate AND per-timer count gate.
// - Top-level pending set by hardware request or software write of one.
// - Bit 5 picks whether top-level ack also needs interrupt enable.
// - Enable clears on acknowledge, sets on return, commands; 0 blocks non-top.
// - Arbitration bit is software only: 0 concurrent, 1 nested.
// - Three-bit current priority, 000 highest; preempt when strictly higher.
// - On preemption the old priority is saved to the nesting register.
// - Flags saved on each interrupt, restored on return, seven deep.
// - Carry takes ALU carry; set, clear and complement commands.
// - Zero flag follows zero result for affected operations.
// - Sign flag copies result top bit.
// - Overflow flag follows two's-complement overflow.
// - Decimal adjust flag records add versus subtract.
// - Half carry records carry or borrow at bit 3.
// - Data space flag set by sdm, cleared by spm; picks data pointers.
// - Pointers hold a five-bit block number of eight registers.
// - Mode bit set by twin-pointer sets, cleared by single set.
// - Single mode starts at nearest even block at or below.
// - Twin mode: r0-r7 low pointer block, r8-r15 high pointer block.
// - Pointer bits 1:0 and flag bit 1 always read zero.
`timescale 1ns/10ps
module csr_regs
  import csr_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_enable,
  input wire csr_wr_t reg_wr,
  input wire logic [7:0] reg_rd_addr,
  input wire csr_cmd_t core_cmd,
  input wire logic [2:0] cmd_priority,
  input wire logic [4:0] cmd_block,
  input wire csr_alu_flags_t alu_flags,
  input wire csr_alu_upd_t alu_upd,
  input wire logic top_level_request,
  input wire logic top_level_mask_mode,
  input wire logic timer_count_gate,
  input wire logic [3:0] wreg_index,
  output logic [7:0] reg_rdata,
  output logic [7:0] interrupt_control,
  output logic [7:0] cpu_flags,
  output logic [7:0] working_pointer_low,
  output logic [7:0] working_pointer_high,
  output logic timer_enable,
  output logic top_level_ack_ok,
  output logic maskable_ok,
  output logic nested_mode,
  output logic data_space_select,
  output logic [2:0] nesting_control_reg,
  output logic nesting_save,
  output logic [2:0] flag_depth,
  output logic stack_overflow,
  output logic [7:0] wreg_phys_addr
);
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic hit(input csr_wr_t w, input logic [7:0] a);
    hit = w.we && (w.addr == a);
  endfunction

  wire logic wr_ic;
  wire logic wr_fl;
  wire logic wr_rp0;
  wire logic wr_rp1;
  assign wr_ic = hit(reg_wr, CSR_ADDR_INTERRUPT_CONTROL);
  assign wr_fl = hit(reg_wr, CSR_ADDR_CPU_FLAGS);
  assign wr_rp0 = hit(reg_wr, CSR_ADDR_WORKING_POINTER_LOW);
  assign wr_rp1 = hit(reg_wr, CSR_ADDR_WORKING_POINTER_HIGH);

  wire logic is_iack;
  wire logic is_iret;
  wire logic [2:0] cur_prio;
  wire logic preempt;
  assign is_iack = (core_cmd == CSR_CMD_IACK);
  assign is_iret = (core_cmd == CSR_CMD_IRET);
  assign cur_prio = interrupt_control[2:CSR_IC_PRIO_LSB];
  // Lower code means higher priority
  // Equal priority never preempts; it waits for the running routine
  assign preempt = is_iack && (cmd_priority < cur_prio);

  // ----------------------------------------------------------------
  // Flag save stack
  // ----------------------------------------------------------------
  // Flip-flop storage indexed by depth; the core's memory stack is
  // the real copy, this mirror lets return restore in one cycle.
  // The mirror is not reset: depth zero marks every entry unused.
  logic [7:0] flag_stack [CSR_NEST_DEPTH];
  logic [2:0] prio_stack [CSR_NEST_DEPTH];
  wire logic can_push;
  wire logic can_pop;
  wire logic [2:0] top_idx;
  assign can_push = is_iack && (flag_depth < 3'(CSR_NEST_DEPTH));
  assign can_pop = is_iret && (flag_depth != 3'h0);
  // Wraps at depth zero; only read when something can be popped
  assign top_idx = flag_depth - 3'h1;

  // ----------------------------------------------------------------
  // Next interrupt control
  // ----------------------------------------------------------------
  logic [7:0] next_ic;
  always_comb
  begin
    next_ic = interrupt_control;
    if (wr_ic)
    begin
      next_ic = reg_wr.wdata;
      // Writing a zero does not drop a pending top-level request
      next_ic[CSR_IC_PEND] = reg_wr.wdata[CSR_IC_PEND] |
        interrupt_control[CSR_IC_PEND];
    end
    case (core_cmd)
      CSR_CMD_EI: next_ic[CSR_IC_ENABLE] = 1'b1;
      CSR_CMD_MASK_ALL: next_ic[CSR_IC_ENABLE] = 1'b0;
      CSR_CMD_IACK:
      begin
        next_ic[CSR_IC_ENABLE] = 1'b0;
        next_ic[2:0] = cmd_priority;
      end
      CSR_CMD_IRET:
      begin
        next_ic[CSR_IC_ENABLE] = 1'b1;
        // With nothing saved, return only sets the enable bit
        if (can_pop)
          next_ic[2:0] = prio_stack[top_idx];
      end
      default: ;
    endcase
    // Hardware set wins over any software clear in the same cycle
    if (top_level_request)
      next_ic[CSR_IC_PEND] = 1'b1;
  end

  // ----------------------------------------------------------------
  // Next flags
  // ----------------------------------------------------------------
  logic [7:0] next_fl;
  always_comb
  begin
    next_fl = cpu_flags;
    if (wr_fl)
      next_fl = reg_wr.wdata;
    if (alu_upd.carry)
      next_fl[CSR_FL_CARRY] = alu_flags.carry;
    if (alu_upd.zsv)
    begin
      next_fl[CSR_FL_ZERO] = alu_flags.zero;
      next_fl[CSR_FL_SIGN] = alu_flags.sign;
      next_fl[CSR_FL_OVF] = alu_flags.ovf;
    end
    if (alu_upd.dadj)
      next_fl[CSR_FL_DADJ] = alu_flags.dadj;
    if (alu_upd.half)
      next_fl[CSR_FL_HALF] = alu_flags.half;
    case (core_cmd)
      CSR_CMD_SCF: next_fl[CSR_FL_CARRY] = 1'b1;
      CSR_CMD_RCF: next_fl[CSR_FL_CARRY] = 1'b0;
      CSR_CMD_CCF: next_fl[CSR_FL_CARRY] = ~cpu_flags[CSR_FL_CARRY];
      CSR_CMD_SDM: next_fl[CSR_FL_DATA] = 1'b1;
      CSR_CMD_SPM: next_fl[CSR_FL_DATA] = 1'b0;
      CSR_CMD_IRET:
        if (can_pop)
          next_fl = flag_stack[top_idx];
      default: ;
    endcase
    next_fl[CSR_FL_RSVD] = 1'b0;
  end

  // ----------------------------------------------------------------
  // Next pointers
  // ----------------------------------------------------------------
  logic [7:0] next_rp0;
  logic [7:0] next_rp1;
  always_comb
  begin
    next_rp0 = working_pointer_low;
    next_rp1 = working_pointer_high;
    if (wr_rp0)
      next_rp0 = reg_wr.wdata;
    if (wr_rp1)
      next_rp1 = reg_wr.wdata;
    case (core_cmd)
      CSR_CMD_SRP:
      begin
        next_rp0 = {cmd_block, 3'b000};
        next_rp1[CSR_RP_MODE] = 1'b0;
      end
      // Twin sets mark the mode in both pointers so they read back alike
      CSR_CMD_SRP_LOW:
      begin
        next_rp0 = {cmd_block, 3'b100};
        next_rp1[CSR_RP_MODE] = 1'b1;
      end
      CSR_CMD_SRP_HIGH:
      begin
        next_rp1 = {cmd_block, 3'b100};
        next_rp0[CSR_RP_MODE] = 1'b1;
      end
      default: ;
    endcase
    next_rp0[1:0] = 2'b00;
    next_rp1[1:0] = 2'b00;
  end

  // ----------------------------------------------------------------
  // Read mux and status
  // ----------------------------------------------------------------
  // Reads show the value after this edge's updates, so a write and a
  // read of one register in the same cycle return the new value
  wire logic [7:0] rd_mux;
  assign rd_mux =
    (reg_rd_addr == CSR_ADDR_INTERRUPT_CONTROL) ? next_ic :
    (reg_rd_addr == CSR_ADDR_CPU_FLAGS) ? next_fl :
    (reg_rd_addr == CSR_ADDR_WORKING_POINTER_LOW) ? next_rp0 :
    (reg_rd_addr == CSR_ADDR_WORKING_POINTER_HIGH) ? next_rp1 : 8'h00;

  wire logic next_tl_ack;
  assign next_tl_ack = next_ic[CSR_IC_ACKSEL]
    ? (top_level_mask_mode && next_ic[CSR_IC_ENABLE])
    : top_level_mask_mode;

  wire logic [7:0] map_addr;
  csr_wreg_map u_map (
    .pointer_low(next_rp0),
    .pointer_high(next_rp1),
    .wreg_index(wreg_index),
    .phys_addr(map_addr)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      // Reset beats the clock enable so a frozen core still comes up clean
      interrupt_control <= CSR_RESET_INTERRUPT_CONTROL;
      cpu_flags <= CSR_RESET_CPU_FLAGS;
      working_pointer_low <= CSR_RESET_POINTER;
      working_pointer_high <= CSR_RESET_POINTER;
      flag_depth <= 3'h0;
      nesting_control_reg <= 3'h0;
      nesting_save <= 1'b0;
      stack_overflow <= 1'b0;
    end
    else if (clock_enable)
    begin
      interrupt_control <= next_ic;
      cpu_flags <= next_fl;
      working_pointer_low <= next_rp0;
      working_pointer_high <= next_rp1;
      nesting_save <= preempt;
      if (preempt)
        nesting_control_reg <= cur_prio;
      if (can_push)
        flag_depth <= flag_depth + 3'h1;
      else if (can_pop)
        flag_depth <= top_idx;
      stack_overflow <= is_iack && !can_push;
    end
  end

  always_ff @(posedge clock)
  begin
    if (clock_enable && can_push)
    begin
      flag_stack[flag_depth] <= cpu_flags;
      prio_stack[flag_depth] <= cur_prio;
    end
  end

  // Outputs registered from the same next values as the state
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      reg_rdata <= 8'h00;
      timer_enable <= 1'b0;
      top_level_ack_ok <= 1'b0;
      maskable_ok <= 1'b0;
      nested_mode <= 1'b0;
      data_space_select <= 1'b0;
      wreg_phys_addr <= 8'h00;
    end
    else if (clock_enable)
    begin
      reg_rdata <= rd_mux;
      timer_enable <= next_ic[CSR_IC_GATE] && timer_count_gate;
      top_level_ack_ok <= next_tl_ack;
      maskable_ok <= next_ic[CSR_IC_ENABLE];
      nested_mode <= next_ic[CSR_IC_ARB];
      data_space_select <= next_fl[CSR_FL_DATA];
      wreg_phys_addr <= map_addr;
    end
  end
endmodule

/* bench/csr_regs_properties.sv */
// Concurrent checks on the system control register ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
module csr_regs_properties
  import csr_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_enable,
  input wire csr_cmd_t core_cmd,
  input wire logic [2:0] cmd_priority,
  input wire logic [4:0] cmd_block,
  input wire logic top_level_request,
  input wire logic [3:0] wreg_index,
  input wire logic [7:0] interrupt_control,
  input wire logic [7:0] cpu_flags,
  input wire logic [7:0] working_pointer_low,
  input wire logic [7:0] working_pointer_high,
  input wire logic [2:0] nesting_control_reg,
  input wire logic nesting_save,
  input wire logic [2:0] flag_depth,
  input wire logic [7:0] wreg_phys_addr
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // Index seen at the previous edge, for the mapped address check
  logic [3:0] idx_q;
  always_ff @(posedge clock)
    idx_q <= wreg_index;
  property p_iack;
    clock_enable && core_cmd == CSR_CMD_IACK && flag_depth != 3'h7 |=>
      !interrupt_control[4] && interrupt_control[2:0] == $past(cmd_priority)
      && flag_depth == $past(flag_depth) + 3'h1;
  endproperty
  a_iack: assert property (p_iack)
    else $error("acknowledge did not update control");
  property p_nest;
    clock_enable && core_cmd == CSR_CMD_IACK
      && cmd_priority < interrupt_control[2:0] |=> nesting_save
      && {5'h00, nesting_control_reg} == ($past(interrupt_control) & 8'h07);
  endproperty
  a_nest: assert property (p_nest)
    else $error("preempted priority not saved");
  property p_iret;
    clock_enable && core_cmd == CSR_CMD_IRET |=> interrupt_control[4];
  endproperty
  a_iret: assert property (p_iret)
    else $error("return did not set enable");
  property p_pend;
    clock_enable && top_level_request |=> interrupt_control[6] [*2];
  endproperty
  a_pend: assert property (p_pend)
    else $error("top request not pending");
  property p_ccf;
    clock_enable && core_cmd == CSR_CMD_CCF |=>
      ((cpu_flags ^ $past(cpu_flags)) & 8'h80) == 8'h80;
  endproperty
  a_ccf: assert property (p_ccf)
    else $error("carry not complemented");
  property p_srp;
    clock_enable && core_cmd == CSR_CMD_SRP |=>
      {working_pointer_low[2], working_pointer_high[2]} == 2'h0
      && working_pointer_low[7:3] == $past(cmd_block);
  endproperty
  a_srp: assert property (p_srp)
    else $error("single pointer set wrong");
  property p_rsvd;
    {working_pointer_low[1:0], working_pointer_high[1:0], cpu_flags[1]}
      == 5'h00;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bits not zero");
  property p_map;
    clock_enable |=> wreg_phys_addr == (working_pointer_low[2] ?
      {idx_q[3] ? working_pointer_high[7:3] : working_pointer_low[7:3],
      idx_q[2:0]} : {working_pointer_low[7:4], idx_q});
  endproperty
  a_map: assert property (p_map)
    else $error("working register address wrong");
endmodule
bind csr_regs csr_regs_properties u_props (.clock, .resetn, .clock_enable,
  .core_cmd, .cmd_priority, .cmd_block, .top_level_request, .wreg_index,
  .interrupt_control, .cpu_flags, .working_pointer_low,
  .working_pointer_high, .nesting_control_reg, .nesting_save, .flag_depth,
  .wreg_phys_addr);

/* bench/csr_core_model.sv */
// Core-side model: issues commands, ALU updates and register writes.
// Assumes its tasks are called from one bench process.
`timescale 1ns/10ps
module csr_core_model
  import csr_pkg::*;
(
  input wire logic clock,
  output csr_wr_t reg_wr,
  output csr_cmd_t core_cmd,
  output logic [2:0] cmd_priority,
  output logic [4:0] cmd_block,
  output csr_alu_flags_t alu_flags,
  output csr_alu_upd_t alu_upd
);
  initial
  begin
    reg_wr = '0;
    core_cmd = CSR_CMD_NONE;
    {cmd_priority, cmd_block, alu_flags, alu_upd} = '0;
  end
  // Held for the edge that takes it; qualifiers go stale afterwards
  task automatic op(input csr_cmd_t c, input logic [2:0] p,
    input logic [4:0] b, input logic [5:0] f, input logic [3:0] u);
    @(posedge clock);
    core_cmd <= c;
    {cmd_priority, cmd_block, alu_flags, alu_upd} <= {p, b, f, u};
    @(posedge clock);
    core_cmd <= CSR_CMD_NONE;
    {cmd_priority, cmd_block, alu_flags, alu_upd} <= {~p, ~b, ~f, 4'h0};
  endtask
  // Requests are masked first so none can race a control write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == CSR_ADDR_INTERRUPT_CONTROL)
      op(CSR_CMD_MASK_ALL, 3'h0, 5'h00, 6'h00, 4'h0);
    @(posedge clock);
    reg_wr <= '{1'b1, a, d};
    @(posedge clock);
    reg_wr <= '{1'b0, ~a, ~d};
  endtask
endmodule

/* bench/csr_regs_tb_top.sv */
// Self-checking bench for the system control registers.
// Assumes the core model drives commands; the bench drives the rest.
`timescale 1ns/10ps
module csr_regs_tb_top
  import csr_pkg::*;
();
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic clock_enable = 1'b1;
  logic top_level_request = 1'b0;
  logic top_level_mask_mode = 1'b0;
  logic timer_count_gate = 1'b0;
  logic [3:0] wreg_index = 4'h0;
  logic [7:0] reg_rd_addr = 8'h00;
  csr_wr_t reg_wr;
  csr_cmd_t core_cmd;
  csr_alu_flags_t alu_flags;
  csr_alu_upd_t alu_upd;
  logic [4:0] cmd_block;
  logic [2:0] cmd_priority, nesting_control_reg, flag_depth;
  logic [7:0] reg_rdata, interrupt_control, cpu_flags, wreg_phys_addr;
  logic [7:0] working_pointer_low, working_pointer_high;
  logic timer_enable, top_level_ack_ok, maskable_ok, nested_mode;
  logic data_space_select, nesting_save, stack_overflow;
  int n_fail = 0;
  int num_checks = 0;
  always #25 clock = ~clock;
  csr_core_model core (.clock, .reg_wr, .core_cmd, .cmd_priority,
    .cmd_block, .alu_flags, .alu_upd);
  csr_regs dut (.clock, .resetn, .clock_enable, .reg_wr, .reg_rd_addr,
    .core_cmd, .cmd_priority, .cmd_block, .alu_flags, .alu_upd,
    .top_level_request, .top_level_mask_mode, .timer_count_gate,
    .wreg_index, .reg_rdata, .interrupt_control, .cpu_flags,
    .working_pointer_low, .working_pointer_high, .timer_enable,
    .top_level_ack_ok, .maskable_ok, .nested_mode, .data_space_select,
    .nesting_control_reg, .nesting_save, .flag_depth, .stack_overflow,
    .wreg_phys_addr);
  task automatic chk(input string nm, input logic [7:0] s, e);
    num_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cmd(input csr_cmd_t c, input logic [4:0] b);
    core.op(c, 3'h0, b, 6'h00, 4'h0);
  endtask
  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clock);
    reg_rd_addr <= a;
    @(posedge clock);
    #1 chk("reg_rdata", reg_rdata, e);
  endtask
  task automatic ix(input logic [3:0] i, input logic [7:0] e);
    @(posedge clock);
    wreg_index <= i;
    settle;
    chk("wreg_phys_addr", wreg_phys_addr, e);
  endtask
  task automatic t_reset;
    rd(8'hE6, 8'h87);
    rd(8'hE7, 8'h00);
    rd(8'hE5, 8'h00);
    @(posedge clock);
    timer_count_gate <= 1'b1;
    top_level_mask_mode <= 1'b1;
    settle;
    chk("timer_enable", 8'(timer_enable), 8'h01);
  endtask
  task automatic t_intc;
    core.wr(8'hE6, 8'h0B);
    rd(8'hE6, 8'h0B);
    chk("nested_mode", 8'(nested_mode), 8'h01);
    chk("timer_enable", 8'(timer_enable), 8'h00);
    chk("top_level_ack_ok", 8'(top_level_ack_ok), 8'h01);
    core.op(CSR_CMD_IACK, 3'h1, 5'h00, 6'h00, 4'h0);
    rd(8'hE6, 8'h09);
    chk("nesting", 8'(nesting_control_reg), 8'h03);
    cmd(CSR_CMD_IRET, 5'h00);
    rd(8'hE6, 8'h1B);
    core.wr(8'hE6, 8'h20);
    rd(8'hE6, 8'h20);
    chk("top_level_ack_ok", 8'(top_level_ack_ok), 8'h00);
    cmd(CSR_CMD_EI, 5'h00);
    rd(8'hE6, 8'h30);
    chk("top_level_ack_ok", 8'(top_level_ack_ok), 8'h01);
    chk("maskable_ok", 8'(maskable_ok), 8'h01);
    @(posedge clock);
    top_level_request <= 1'b1;
    @(posedge clock);
    top_level_request <= 1'b0;
    rd(8'hE6, 8'h70);
    @(posedge clock);
    top_level_mask_mode <= 1'b0;
    settle;
    chk("top_level_ack_ok", 8'(top_level_ack_ok), 8'h00);
  endtask
  task automatic t_flags;
    core.op(CSR_CMD_NONE, 3'h0, 5'h00, 6'h3F, 4'hF);
    rd(8'hE7, 8'hFC);
    core.op(CSR_CMD_NONE, 3'h0, 5'h00, 6'h00, 4'h4);
    rd(8'hE7, 8'h8C);
    core.op(CSR_CMD_NONE, 3'h0, 5'h00, 6'h00, 4'h3);
    rd(8'hE7, 8'h80);
    cmd(CSR_CMD_CCF, 5'h00);
    rd(8'hE7, 8'h00);
    cmd(CSR_CMD_SCF, 5'h00);
    cmd(CSR_CMD_SDM, 5'h00);
    rd(8'hE7, 8'h81);
    chk("data_space", 8'(data_space_select), 8'h01);
    cmd(CSR_CMD_RCF, 5'h00);
    cmd(CSR_CMD_SPM, 5'h00);
    rd(8'hE7, 8'h00);
    core.wr(8'hE7, 8'hFF);
    rd(8'hE7, 8'hFD);
  endtask
  task automatic t_stack;
    cmd(CSR_CMD_IACK, 5'h00);
    cmd(CSR_CMD_RCF, 5'h00);
    rd(8'hE7, 8'h7D);
    cmd(CSR_CMD_IRET, 5'h00);
    rd(8'hE7, 8'hFD);
    repeat (8) cmd(CSR_CMD_IACK, 5'h00);
    #1 chk("flag_depth", 8'(flag_depth), 8'h07);
    chk("stack_overflow", 8'(stack_overflow), 8'h01);
    repeat (7) cmd(CSR_CMD_IRET, 5'h00);
    #1 chk("flag_depth", 8'(flag_depth), 8'h00);
  endtask
  task automatic t_ptr;
    cmd(CSR_CMD_SRP, 5'h03);
    rd(8'hE8, 8'h18);
    ix(4'h5, 8'h15);
    ix(4'hF, 8'h1F);
    cmd(CSR_CMD_SRP_LOW, 5'h04);
    rd(8'hE9, 8'h04);
    cmd(CSR_CMD_SRP_HIGH, 5'h1F);
    rd(8'hE8, 8'h24);
    rd(8'hE9, 8'hFC);
    ix(4'h2, 8'h22);
    ix(4'hF, 8'hFF);
    core.wr(8'hE8, 8'hFF);
    rd(8'hE8, 8'hFC);
  endtask
  // Frozen edges must not take a command; then a reset in mid-run
  task automatic t_misc;
    @(posedge clock);
    clock_enable <= 1'b0;
    cmd(CSR_CMD_RCF, 5'h00);
    #1 chk("cpu_flags", cpu_flags, 8'hFD);
    @(posedge clock);
    clock_enable <= 1'b1;
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    rd(8'hE6, 8'h87);
  endtask
  task automatic final_report;
    if (n_fail == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    t_reset;
    t_intc;
    t_flags;
    t_stack;
    t_ptr;
    t_misc;
    final_report;
  end
endmodule
